//--- core/tog_map.svh
// Purpose: Register indices, field positions, reset values and frame constants.
// Assumes: Word indices; byte address on the bus is four times the index.
// Notes: Definitions only.
`ifndef TOG_MAP_SVH
`define TOG_MAP_SVH

`define TOG_IDX_W 14
`define TOG_IDX_ONE_WAY 14'h1120
`define TOG_IDX_REQ 14'h1140
`define TOG_IDX_LEN 14'h1141
`define TOG_IDX_GEN_ON 14'h1142

`define TOG_RST_ONE_WAY 2'h0
`define TOG_RST_REQ 2'h0
`define TOG_RST_LEN 16'h0000
`define TOG_RST_GEN_ON 1'h1

`define TOG_BIT_ONE_WAY_EN 0
`define TOG_BIT_NO_RF 1
`define TOG_BIT_XON 0
`define TOG_BIT_XOFF 1
`define TOG_BIT_GEN_ON 0

`define TOG_REQ_XON 2'h1
`define TOG_REQ_XOFF 2'h2
`define TOG_REQ_BOTH 2'h3

`define TOG_FRAME_BYTES 6'h3c
`define TOG_FRAME_LAST 6'h3b
`define TOG_CTRL_DA 48'h0180c2000001
`define TOG_CTRL_TYPE 16'h8808
`define TOG_PAUSE_OPCODE 16'h0001
`define TOG_SRC_ADDR 48'h02aabbccdd01

`endif

//--- core/tog_pkg.sv
// Purpose: Types shared by the transmit control logic.
// Assumes: Constants live in tog_map.svh.
// Notes: Types only.
package tog_pkg;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_CLIENT,
		ST_PAUSE
	} tog_state_t;
	typedef logic [7:0] tog_byte_t;
endpackage : tog_pkg

//--- core/tog_pause_frame.sv
// Purpose: Byte sequencer for one pause control frame of 60 bytes.
// Assumes: The caller registers the bytes; adv_i moves to the next byte.
// Notes: No frame check sequence is added here; it is inserted downstream.
`timescale 1ns/1ps
`default_nettype none
`include "tog_map.svh"

module tog_pause_frame #(
	parameter logic [47:0] SRC_ADDR = `TOG_SRC_ADDR
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire logic [15:0] quanta_i,
	input wire logic adv_i,
	output tog_pkg::tog_byte_t byte_o,
	output logic first_o,
	output logic last_o,
	output logic busy_o
);
	logic [5:0] idx_reg;
	logic [5:0] idx_next;
	logic busy_reg;
	logic busy_next;
	logic [15:0] quanta_reg;
	logic [47:0] da;
	logic [15:0] ctype;
	logic [15:0] opcode;

	assign da = `TOG_CTRL_DA;
	assign ctype = `TOG_CTRL_TYPE;
	assign opcode = `TOG_PAUSE_OPCODE;
	assign busy_o = busy_reg;
	assign first_o = busy_reg && (idx_reg == 6'h00);
	assign last_o = busy_reg && (idx_reg == `TOG_FRAME_LAST);
	assign idx_next = last_o ? 6'h00 : idx_reg + 6'h01;
	assign busy_next = start_i ? 1'b1 : (adv_i && last_o ? 1'b0 : busy_reg);

	////////////////////////////////////////////////////////////////////////////
	// control frame layout
	always_comb begin
		byte_o = 8'h00;
		case (idx_reg)
			6'h00: byte_o = da[47:40];
			6'h01: byte_o = da[39:32];
			6'h02: byte_o = da[31:24];
			6'h03: byte_o = da[23:16];
			6'h04: byte_o = da[15:8];
			6'h05: byte_o = da[7:0];
			6'h06: byte_o = SRC_ADDR[47:40];
			6'h07: byte_o = SRC_ADDR[39:32];
			6'h08: byte_o = SRC_ADDR[31:24];
			6'h09: byte_o = SRC_ADDR[23:16];
			6'h0a: byte_o = SRC_ADDR[15:8];
			6'h0b: byte_o = SRC_ADDR[7:0];
			6'h0c: byte_o = ctype[15:8];
			6'h0d: byte_o = ctype[7:0];
			6'h0e: byte_o = opcode[15:8];
			6'h0f: byte_o = opcode[7:0];
			6'h10: byte_o = quanta_reg[15:8];
			6'h11: byte_o = quanta_reg[7:0];
			default: byte_o = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			idx_reg <= 6'h00;
			busy_reg <= 1'b0;
			quanta_reg <= 16'h0000;
		end else begin
			busy_reg <= busy_next;
			if (start_i) begin
				idx_reg <= 6'h00;
				quanta_reg <= quanta_i;
			end else if (adv_i && busy_reg) begin
				idx_reg <= idx_next;
			end
		end
	end
endmodule : tog_pause_frame
`default_nettype wire

//--- core/tog_tx_ctrl.sv
// Purpose: Transmit control: one-way mode, fault signalling and pause frame insertion.
// Assumes: Classic Wishbone slave, 32-bit data; byte address is four times the word index.
// Notes: Byte-wide client stream; the output stage is a single register slice.
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "tog_map.svh"

module tog_tx_ctrl (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [15:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [7:0] cl_data_i,
	input wire logic cl_valid_i,
	input wire logic cl_sop_i,
	input wire logic cl_eop_i,
	output logic cl_ready_o,
	output logic [7:0] tx_data_o,
	output logic tx_valid_o,
	output logic tx_sop_o,
	output logic tx_eop_o,
	input wire logic tx_ready_i,
	input wire logic local_fault_i,
	output logic remote_fault_o
);
	////////////////////////////////////////////////////////////////////////////
	// Register bus.
	logic ack_reg;
	logic [31:0] rdat_reg;
	logic [31:0] rdat_next;
	logic [`TOG_IDX_W-1:0] idx;
	logic req_cycle;
	logic wr_en;
	logic hit_one_way;
	logic hit_req;
	logic hit_len;
	logic hit_gen_on;
	logic [1:0] one_way_reg;
	logic [1:0] req_reg;
	logic [1:0] req_next;
	logic [15:0] len_reg;
	logic gen_on_reg;

	assign idx = wb_adr_i[15:2];
	assign req_cycle = wb_cyc_i && wb_stb_i;
	// A write lands on the edge where the master samples ack high.
	assign wr_en = req_cycle && wb_we_i && ack_reg;
	assign hit_one_way = (idx == `TOG_IDX_ONE_WAY);
	assign hit_req = (idx == `TOG_IDX_REQ);
	assign hit_len = (idx == `TOG_IDX_LEN);
	assign hit_gen_on = (idx == `TOG_IDX_GEN_ON);
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdat_reg;

	// Unmapped and reserved bits read as zero; the request reads its pending bits.
	assign rdat_next = hit_one_way ? {30'h0, one_way_reg} :
		hit_req ? {30'h0, req_reg} :
		hit_len ? {16'h0000, len_reg} :
		hit_gen_on ? {31'h0, gen_on_reg} : 32'h00000000;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			rdat_reg <= 32'h00000000;
		end else begin
			ack_reg <= req_cycle && !ack_reg;
			if (req_cycle && !ack_reg) begin
				rdat_reg <= rdat_next;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Configuration registers.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			one_way_reg <= `TOG_RST_ONE_WAY;
			len_reg <= `TOG_RST_LEN;
			gen_on_reg <= `TOG_RST_GEN_ON;
		end else if (wr_en) begin
			if (hit_one_way && wb_sel_i[0]) begin
				one_way_reg <= wb_dat_i[1:0];
			end
			if (hit_len && wb_sel_i[0]) begin
				len_reg[7:0] <= wb_dat_i[7:0];
			end
			if (hit_len && wb_sel_i[1]) begin
				len_reg[15:8] <= wb_dat_i[15:8];
			end
			if (hit_gen_on && wb_sel_i[0]) begin
				gen_on_reg <= wb_dat_i[`TOG_BIT_GEN_ON];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Fault handling.
	logic one_way_on;
	logic rf_allowed;
	logic rf_hold;
	tog_pkg::tog_state_t state_reg;
	tog_pkg::tog_state_t state_next;

	assign one_way_on = one_way_reg[`TOG_BIT_ONE_WAY_EN];
	assign rf_allowed = !one_way_on || !one_way_reg[`TOG_BIT_NO_RF];
	// Outside one-way mode a local fault stops frame starts entirely.
	assign rf_hold = local_fault_i && !one_way_on;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			remote_fault_o <= 1'b0;
		end else begin
			remote_fault_o <= local_fault_i && rf_allowed && (state_reg == tog_pkg::ST_IDLE);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pause request handling.
	logic req_pending;
	logic req_both;
	logic req_drop;
	logic pause_start;
	logic [15:0] pause_quanta;
	logic adv;
	tog_pkg::tog_byte_t pf_byte;
	logic pf_first;
	logic pf_last;
	logic pf_busy;

	assign req_pending = (req_reg == `TOG_REQ_XON) || (req_reg == `TOG_REQ_XOFF);
	assign req_both = (req_reg == `TOG_REQ_BOTH);
	assign req_drop = req_both || ((req_reg != 2'h0) && !gen_on_reg);
	// start only at a frame boundary
	assign pause_start = req_pending && gen_on_reg && !rf_hold && (state_reg == tog_pkg::ST_IDLE);
	assign pause_quanta = (req_reg == `TOG_REQ_XOFF) ? len_reg : 16'h0000;

	// A write in the same cycle as the self-clear wins, so no request is lost.
	always_comb begin
		req_next = req_reg;
		if (pause_start || req_drop) begin
			req_next = 2'h0;
		end
		if (wr_en && hit_req && wb_sel_i[0]) begin
			req_next = wb_dat_i[1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			req_reg <= `TOG_RST_REQ;
		end else begin
			req_reg <= req_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Output selection.
	logic load_client;
	logic load_pause;

	assign adv = !tx_valid_o || tx_ready_i;
	assign cl_ready_o = adv && (state_reg == tog_pkg::ST_CLIENT);
	assign load_client = cl_ready_o && cl_valid_i;
	assign load_pause = adv && pf_busy && (state_reg == tog_pkg::ST_PAUSE);

	tog_pause_frame u_frame (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(pause_start),
		.quanta_i(pause_quanta),
		.adv_i(load_pause),
		.byte_o(pf_byte),
		.first_o(pf_first),
		.last_o(pf_last),
		.busy_o(pf_busy)
	);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			tog_pkg::ST_IDLE: begin
				if (pause_start) begin
					state_next = tog_pkg::ST_PAUSE;
				end else if (cl_valid_i && cl_sop_i && !rf_hold) begin
					state_next = tog_pkg::ST_CLIENT;
				end
			end
			tog_pkg::ST_CLIENT: begin
				// client frame runs to its end
				if (load_client && cl_eop_i) begin
					state_next = tog_pkg::ST_IDLE;
				end
			end
			tog_pkg::ST_PAUSE: begin
				if (load_pause && pf_last) begin
					state_next = tog_pkg::ST_IDLE;
				end
			end
			default: begin
				state_next = tog_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= tog_pkg::ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_data_o <= 8'h00;
			tx_valid_o <= 1'b0;
			tx_sop_o <= 1'b0;
			tx_eop_o <= 1'b0;
		end else if (load_client) begin
			tx_data_o <= cl_data_i;
			tx_valid_o <= 1'b1;
			tx_sop_o <= cl_sop_i;
			tx_eop_o <= cl_eop_i;
		end else if (load_pause) begin
			tx_data_o <= pf_byte;
			tx_valid_o <= 1'b1;
			tx_sop_o <= pf_first;
			tx_eop_o <= pf_last;
		end else if (adv) begin
			tx_valid_o <= 1'b0;
			tx_sop_o <= 1'b0;
			tx_eop_o <= 1'b0;
		end
	end
endmodule : tog_tx_ctrl
`default_nettype wire

//--- bench/tog_tx_ctrl_sva.sv
// Purpose: Port checks for the transmit control block.
// Assumes: One clock, synchronous active-high reset.
// Notes: Watches only the ports it needs.
`timescale 1ns/1ps
`default_nettype none
module tog_tx_ctrl_sva (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic [7:0] cl_data_i,
	input wire logic cl_valid_i,
	input wire logic cl_ready_o,
	input wire logic [7:0] tx_data_o,
	input wire logic tx_valid_o,
	input wire logic tx_sop_o,
	input wire logic tx_eop_o,
	input wire logic tx_ready_i,
	input wire logic local_fault_i,
	input wire logic remote_fault_o
);
	logic in_frame_reg;
	logic in_frame_next;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// A frame stays open from an accepted start byte to its accepted end byte.
	assign in_frame_next = (tx_valid_o && tx_ready_i) ? !tx_eop_o : in_frame_reg;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			in_frame_reg <= 1'b0;
		end else begin
			in_frame_reg <= in_frame_next;
		end
	end
	bus_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing after request");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	fault_cause_a: assert property (remote_fault_o |-> $past(local_fault_i))
		else $error("remote fault without local fault");
	fault_end_a: assert property (!local_fault_i |=> !remote_fault_o)
		else $error("remote fault outlives local fault");
	stall_hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o
		&& $stable(tx_data_o) && $stable(tx_sop_o) && $stable(tx_eop_o))
		else $error("byte changed under stall");
	start_valid_a: assert property (tx_sop_o |-> tx_valid_o)
		else $error("start flag without valid");
	client_pass_a: assert property (cl_valid_i && cl_ready_o |=>
		tx_valid_o && tx_data_o == $past(cl_data_i))
		else $error("client byte not forwarded");
	no_split_a: assert property (tx_valid_o && in_frame_reg |-> !tx_sop_o)
		else $error("frame started inside a frame");
endmodule : tog_tx_ctrl_sva
bind tog_tx_ctrl tog_tx_ctrl_sva chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .cl_data_i(cl_data_i), .cl_valid_i(cl_valid_i),
	.cl_ready_o(cl_ready_o), .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o),
	.tx_sop_o(tx_sop_o), .tx_eop_o(tx_eop_o), .tx_ready_i(tx_ready_i),
	.local_fault_i(local_fault_i), .remote_fault_o(remote_fault_o));
`default_nettype wire

//--- bench/tog_link_sink.sv
// Purpose: Link partner model that takes the transmit stream.
// Assumes: Byte stream with valid and ready.
// Notes: Keeps the last frame and a frame count.
`timescale 1ns/1ps
`default_nettype none
module tog_link_sink (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic stall_i,
	input wire logic [7:0] data_i,
	input wire logic valid_i,
	input wire logic sop_i,
	input wire logic eop_i,
	output logic ready_o
);
	logic [7:0] fr [0:255];
	logic [7:0] cnt;
	int nfr;
	int len;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ready_o <= 1'b0;
			cnt <= 8'h00;
			nfr <= 0;
			len <= 0;
		end else begin
			// Random stalls make the sender prove it holds each byte.
			ready_o <= !stall_i || ($urandom_range(3) == 0);
			if (valid_i && ready_o) begin
				fr[sop_i ? 8'h00 : cnt] <= data_i;
				cnt <= sop_i ? 8'h01 : cnt + 8'h01;
				if (eop_i) begin
					nfr <= nfr + 1;
					len <= sop_i ? 1 : int'(cnt) + 1;
				end
			end
		end
	end
endmodule : tog_link_sink
`default_nettype wire

//--- bench/tog_tx_ctrl_tb_top.sv
// Purpose: Self-checking bench for the transmit control block.
// Assumes: Classic Wishbone master; link partner model on the stream.
// Notes: Random quanta and client data from a fixed seed.
`timescale 1ns/1ps
`default_nettype none
`include "tog_map.svh"
module tog_tx_ctrl_tb_top;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [15:0] adr = 16'h0000;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat = 32'h0;
	logic [7:0] cdat = 8'h00;
	logic cval = 1'b0;
	logic csop = 1'b0;
	logic ceop = 1'b0;
	logic lf = 1'b0;
	logic stall = 1'b0;
	logic [31:0] rdat;
	logic ack;
	logic cready;
	logic [7:0] txd;
	logic txv;
	logic txs;
	logic txe;
	logic txr;
	logic rf;
	logic [31:0] r;
	logic [15:0] q;
	int mismatches = 0;
	int total_checks = 0;
	int n0;
	always #2.5 clk_i = ~clk_i;
	tog_tx_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.cl_data_i(cdat), .cl_valid_i(cval), .cl_sop_i(csop), .cl_eop_i(ceop),
		.cl_ready_o(cready), .tx_data_o(txd), .tx_valid_o(txv), .tx_sop_o(txs), .tx_eop_o(txe),
		.tx_ready_i(txr), .local_fault_i(lf), .remote_fault_o(rf));
	tog_link_sink sink_u (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall), .data_i(txd),
		.valid_i(txv), .sop_i(txs), .eop_i(txe), .ready_o(txr));
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : summarize
	task automatic tmo();
		mismatches++;
		summarize();
	endtask : tmo
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [13:0] ix, input logic [3:0] s,
		input logic [31:0] d, output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {ix, 2'h0};
		sel <= s;
		dat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) tmo();
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	task automatic req(input logic [31:0] v);
		n0 = sink_u.nfr;
		wb(1'b1, `TOG_IDX_REQ, 4'hf, v, r);
	endtask : req
	// Expected pause frame byte; the frame pads with zeros after the quanta.
	function automatic logic [7:0] pb(input int i, input logic [15:0] qv);
		logic [143:0] h;
		h = {`TOG_CTRL_DA, `TOG_SRC_ADDR, `TOG_CTRL_TYPE, `TOG_PAUSE_OPCODE, qv};
		return (i < 18) ? h[143 - 8 * i -: 8] : 8'h00;
	endfunction : pb
	task automatic wait_fr(input int n);
		int i;
		i = 0;
		while (sink_u.nfr != n && i < 1000) begin
			@(posedge clk_i);
			i++;
		end
		if (i >= 1000) tmo();
	endtask : wait_fr
	task automatic pause_chk(input int n, input logic [15:0] qv);
		int i;
		wait_fr(n);
		chk(sink_u.len, 32'd60);
		for (i = 0; i < 60; i++) chk({24'h0, sink_u.fr[i]}, {24'h0, pb(i, qv)});
	endtask : pause_chk
	task automatic cl_send(input int l);
		int i;
		int n;
		for (i = 0; i < l; i++) begin
			cdat <= 8'($urandom());
			cval <= 1'b1;
			csop <= (i == 0);
			ceop <= (i == l - 1);
			n = 0;
			do begin
				@(posedge clk_i);
				n++;
			end while (cready !== 1'b1 && n < 200);
			if (n >= 200) tmo();
		end
		cval <= 1'b0;
	endtask : cl_send
	initial begin
		logic [13:0] ix [5];
		logic [31:0] rv [5];
		logic [1:0] cf [4];
		int i;
		ix = '{`TOG_IDX_ONE_WAY, `TOG_IDX_REQ, `TOG_IDX_LEN, `TOG_IDX_GEN_ON, 14'h1143};
		rv = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h0};
		cf = '{2'h1, 2'h3, 2'h2, 2'h0};
		void'($urandom(17));
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		for (i = 0; i < 5; i++) begin
			wb(1'b0, ix[i], 4'hf, 32'h0, r);
			chk(r, rv[i]);
		end
		q = 16'($urandom()) | 16'h0001;
		wb(1'b1, `TOG_IDX_LEN, 4'hf, {16'($urandom()), q}, r);
		wb(1'b1, `TOG_IDX_LEN, 4'h1, 32'hffff_ff5b, r);
		q = {q[15:8], 8'h5b};
		wb(1'b0, `TOG_IDX_LEN, 4'hf, 32'h0, r);
		chk(r, {16'h0, q});
		stall <= 1'b1;
		req(32'h2);
		pause_chk(n0 + 1, q);
		stall <= 1'b0;
		wb(1'b0, `TOG_IDX_REQ, 4'hf, 32'h0, r);
		chk(r, 32'h0);
		req(32'h1);
		pause_chk(n0 + 1, 16'h0);
		for (i = 0; i < 2; i++) begin
			wb(1'b1, `TOG_IDX_GEN_ON, 4'hf, {31'h0, i == 0}, r);
			req(i == 0 ? 32'h3 : 32'h2);
			repeat (80) @(posedge clk_i);
			chk(sink_u.nfr, n0);
			wb(1'b0, `TOG_IDX_REQ, 4'hf, 32'h0, r);
			chk(r, 32'h0);
		end
		wb(1'b1, `TOG_IDX_GEN_ON, 4'hf, 32'h1, r);
		fork
			cl_send(20);
			begin
				repeat (8) @(posedge clk_i);
				req(32'h2);
			end
		join
		// The client frame must arrive whole before the queued pause frame.
		wait_fr(n0 + 1);
		chk(sink_u.len, 32'd20);
		pause_chk(n0 + 2, q);
		lf <= 1'b1;
		for (i = 0; i < 4; i++) begin
			wb(1'b1, `TOG_IDX_ONE_WAY, 4'hf, {{30{1'b1}}, cf[i]}, r);
			wb(1'b0, `TOG_IDX_ONE_WAY, 4'hf, 32'h0, r);
			chk(r, {30'h0, cf[i]});
			chk({31'h0, rf}, {31'h0, cf[i] != 2'h3});
		end
		// Outside one-way mode a local fault holds the request back.
		req(32'h2);
		repeat (80) @(posedge clk_i);
		chk(sink_u.nfr, n0);
		wb(1'b1, `TOG_IDX_ONE_WAY, 4'hf, 32'h1, r);
		pause_chk(n0 + 1, q);
		lf <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk({31'h0, rf}, 32'h0);
		// A reset in mid-run must restore every register; one-way, length and generator enable are in a changed state, the request is already clear.
		wb(1'b1, `TOG_IDX_GEN_ON, 4'hf, 32'h0, r);
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		for (i = 0; i < 5; i++) begin
			wb(1'b0, ix[i], 4'hf, 32'h0, r);
			chk(r, rv[i]);
		end
		summarize();
	end
endmodule : tog_tx_ctrl_tb_top
`default_nettype wire
